// ===== rtl/aac_regs.sv
// Amplifier control bank: I2C slave, registers, fault latching, fade and frame monitor
`timescale 1ns/1ns
module aac_regs #(
    parameter logic [6:0] DEVICE_ADDR = 7'h2A, // Value is arbitrary
    parameter logic [7:0] DEVICE_ID = 8'h5A    // Value is arbitrary
) (
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic sclk_in,
    input wire logic lrck_in,
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_data_out,
    output logic sda_oe_out,
    input wire logic overcurrent_in,
    input wire logic dc_offset_in,
    input wire logic overheat_in,
    output aac_pkg::aac_ctrl_s ctrl_out
);
    if (DEVICE_ADDR[6:3] == 4'h0 || DEVICE_ADDR[6:3] == 4'hF) begin : g_bad_addr
        $error("Device address lies in a reserved I2C range");
    end

    // Pin synchronisers: scl, sda, overcurrent, dc offset, overheat
    logic [4:0] pin_m;
    logic [4:0] pin_s;
    logic [1:0] bus_d;
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            pin_m <= 5'h03;
            pin_s <= 5'h03;
            bus_d <= 2'b11;
        end else begin
            pin_m <= {overheat_in, dc_offset_in, overcurrent_in, sda_in, scl_in};
            pin_s <= pin_m;
            bus_d <= pin_s[1:0];
        end
    end
    wire scl_s = pin_s[0];
    wire sda_s = pin_s[1];
    wire oc_s = pin_s[2];
    wire dc_s = pin_s[3];
    wire ot_s = pin_s[4];
    wire scl_rise = scl_s & ~bus_d[0];
    wire scl_fall = ~scl_s & bus_d[0];
    wire bus_start = scl_s & bus_d[0] & bus_d[1] & ~sda_s;
    wire bus_stop = scl_s & bus_d[0] & ~bus_d[1] & sda_s;

    // Link side: frame edges on the serial bit clock become a toggle
    logic [1:0] lrck_sh;
    logic frame_tgl;
    always_ff @(posedge sclk_in or posedge rst_in) begin
        if (rst_in) begin
            lrck_sh <= 2'b00;
            frame_tgl <= 1'b0;
        end else begin
            lrck_sh <= {lrck_sh[0], lrck_in};
            frame_tgl <= frame_tgl ^ (lrck_sh[0] & ~lrck_sh[1]);
        end
    end
    logic [2:0] tgl_sh;
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) tgl_sh <= 3'b000;
        else tgl_sh <= {tgl_sh[1:0], frame_tgl};
    end
    wire frame_tick = tgl_sh[1] ^ tgl_sh[2];
    // Registers
    logic [7:0] pwr;
    logic [7:0] dig;
    logic [7:0] vcfg;
    logic [7:0] vol_l;
    logic [7:0] vol_r;
    logic [7:0] ostage;
    logic [1:0] oc_scale;
    logic [7:0] clip_mid;
    logic [7:0] clip_low;
    logic fault_oc;
    logic fault_dc;
    logic fault_ot;
    logic clock_fault;
    logic [7:0] gain_l;
    logic [7:0] gain_r;

    // I2C slave
    aac_pkg::aac_i2c_e state;
    logic [7:0] sh;
    logic [3:0] cnt;
    logic ack;
    logic rw;
    logic nack;
    logic [7:0] ptr;
    logic oe;
    logic wr_stb;
    logic [7:0] wr_addr;
    logic [7:0] wr_data;
    wire [7:0] rd_data;
    wire byte_in = ~ack && cnt == 4'h8;

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            state <= aac_pkg::I2C_IDLE;
            sh <= 8'h00;
            cnt <= 4'h0;
            ack <= 1'b0;
            rw <= 1'b0;
            nack <= 1'b0;
            ptr <= 8'h00;
            oe <= 1'b0;
            wr_stb <= 1'b0;
            wr_addr <= 8'h00;
            wr_data <= 8'h00;
        end else begin
            wr_stb <= 1'b0;
            if (bus_start) begin
                state <= aac_pkg::I2C_DEV;
                cnt <= 4'h0;
                ack <= 1'b0;
                oe <= 1'b0;
            end else if (bus_stop) begin
                state <= aac_pkg::I2C_IDLE;
                ack <= 1'b0;
                oe <= 1'b0;
            end else if (scl_rise) begin
                if (ack) begin
                    nack <= sda_s;
                end else if (state != aac_pkg::I2C_RD && state != aac_pkg::I2C_IDLE) begin
                    sh <= {sh[6:0], sda_s};
                    cnt <= cnt + 4'h1;
                end
            end else if (scl_fall) begin
                case (state)
                    aac_pkg::I2C_DEV: begin
                        if (byte_in && sh[7:1] == DEVICE_ADDR) begin
                            ack <= 1'b1;
                            oe <= 1'b1;
                            rw <= sh[0];
                        end else if (byte_in) begin
                            state <= aac_pkg::I2C_IDLE;
                        end else if (ack && rw) begin
                            ack <= 1'b0;
                            state <= aac_pkg::I2C_RD;
                            sh <= rd_data;
                            oe <= ~rd_data[7];
                            cnt <= 4'h1;
                        end else if (ack) begin
                            ack <= 1'b0;
                            oe <= 1'b0;
                            cnt <= 4'h0;
                            state <= aac_pkg::I2C_REG;
                        end
                    end
                    aac_pkg::I2C_REG: begin
                        if (byte_in) begin
                            ptr <= sh;
                            ack <= 1'b1;
                            oe <= 1'b1;
                        end else if (ack) begin
                            ack <= 1'b0;
                            oe <= 1'b0;
                            cnt <= 4'h0;
                            state <= aac_pkg::I2C_WR;
                        end
                    end
                    aac_pkg::I2C_WR: begin
                        if (byte_in) begin
                            wr_stb <= 1'b1;
                            wr_addr <= ptr;
                            wr_data <= sh;
                            ptr <= ptr + 8'h01;
                            ack <= 1'b1;
                            oe <= 1'b1;
                        end else if (ack) begin
                            ack <= 1'b0;
                            oe <= 1'b0;
                            cnt <= 4'h0;
                        end
                    end
                    aac_pkg::I2C_RD: begin
                        if (byte_in) begin
                            oe <= 1'b0;
                            ack <= 1'b1;
                            ptr <= ptr + 8'h01;
                        end else if (!ack) begin
                            oe <= ~sh[6];
                            sh <= {sh[6:0], 1'b0};
                            cnt <= cnt + 4'h1;
                        end else if (nack) begin
                            ack <= 1'b0;
                            state <= aac_pkg::I2C_IDLE;
                        end else begin
                            ack <= 1'b0;
                            sh <= rd_data;
                            oe <= ~rd_data[7];
                            cnt <= 4'h1;
                        end
                    end
                    default: oe <= 1'b0;
                endcase
            end
        end
    end
    assign sda_data_out = 1'b0;
    assign sda_oe_out = oe;
    // Write decode; unlisted and reserved addresses are dropped
    wire hit_pwr = wr_stb && wr_addr == aac_pkg::REG_POWER;
    wire hit_dig = wr_stb && wr_addr == aac_pkg::REG_DIGITAL;
    wire hit_vcfg = wr_stb && wr_addr == aac_pkg::REG_VOLCFG;
    wire hit_left = wr_stb && wr_addr == aac_pkg::REG_LEFT;
    wire hit_right = wr_stb && wr_addr == aac_pkg::REG_RIGHT;
    wire hit_ostage = wr_stb && wr_addr == aac_pkg::REG_OUTSTAGE;
    wire hit_fault = wr_stb && wr_addr == aac_pkg::REG_FAULT;
    wire hit_cmid = wr_stb && wr_addr == aac_pkg::REG_CLIP_MID;
    wire hit_clow = wr_stb && wr_addr == aac_pkg::REG_CLIP_LOW;
    // Reserved codes would leave the serial port or gain stage undefined, so keep the old one
    wire fmt_ok = wr_data[2:0] <= aac_pkg::FMT_LAST;
    wire gain_ok = wr_data[3:2] != aac_pkg::GAIN_RESERVED;

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            pwr <= aac_pkg::RST_POWER;
            dig <= aac_pkg::RST_DIGITAL;
            vcfg <= aac_pkg::RST_VOLCFG;
            vol_l <= aac_pkg::RST_VOLUME;
            vol_r <= aac_pkg::RST_VOLUME;
            ostage <= aac_pkg::RST_OUTSTAGE;
            oc_scale <= aac_pkg::RST_OC_SCALE;
            clip_mid <= aac_pkg::RST_CLIP_MID;
            clip_low <= aac_pkg::RST_CLIP_LOW;
        end else begin
            if (hit_pwr) pwr <= wr_data;
            if (hit_dig && fmt_ok) dig <= wr_data & aac_pkg::WMASK_DIGITAL;
            if (hit_vcfg) vcfg <= wr_data & aac_pkg::WMASK_VOLCFG;
            if (hit_left) vol_l <= wr_data;
            if (hit_right) vol_r <= wr_data;
            if (hit_ostage && gain_ok) ostage <= wr_data;
            if (hit_fault) oc_scale <= wr_data[5:4];
            if (hit_cmid) clip_mid <= wr_data;
            if (hit_clow) clip_low <= wr_data;
        end
    end

    assign rd_data = (ptr == aac_pkg::REG_ID) ? DEVICE_ID :
                     (ptr == aac_pkg::REG_POWER) ? pwr :
                     (ptr == aac_pkg::REG_DIGITAL) ? dig :
                     (ptr == aac_pkg::REG_VOLCFG) ? vcfg :
                     (ptr == aac_pkg::REG_LEFT) ? vol_l :
                     (ptr == aac_pkg::REG_RIGHT) ? vol_r :
                     (ptr == aac_pkg::REG_OUTSTAGE) ? ostage :
                     (ptr == aac_pkg::REG_FAULT) ?
                         {2'b00, oc_scale, clock_fault, fault_oc, fault_dc, fault_ot} :
                     (ptr == aac_pkg::REG_CLIP_MID) ? clip_mid :
                     (ptr == aac_pkg::REG_CLIP_LOW) ? clip_low : 8'h00;

    // Latched faults; a fault present while shut down still wins over the clear
    wire fault_clr = ~pwr[aac_pkg::BIT_SHUTDOWN_N];
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            fault_oc <= 1'b0;
            fault_dc <= 1'b0;
            fault_ot <= 1'b0;
        end else begin
            fault_oc <= oc_s | (fault_oc & ~fault_clr);
            fault_dc <= dc_s | (fault_dc & ~fault_clr);
            fault_ot <= ot_s | (fault_ot & ~fault_clr);
        end
    end

    // Frame period monitor; the partial period before the first tick is judged only against the maximum
    wire speed = dig[aac_pkg::BIT_SPEED];
    logic [11:0] per_cnt;
    logic frame_seen;
    wire [11:0] per_min = speed ? 12'(aac_pkg::DS_MIN_CYC) : 12'(aac_pkg::SS_MIN_CYC);
    wire [11:0] per_max = speed ? 12'(aac_pkg::DS_MAX_CYC) : 12'(aac_pkg::SS_MAX_CYC);
    wire period_ok = per_cnt >= per_min && per_cnt <= per_max;
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            per_cnt <= 12'h000;
            clock_fault <= 1'b0;
            frame_seen <= 1'b0;
        end else begin
            per_cnt <= frame_tick ? 12'h000 : (per_cnt == 12'hFFF ? per_cnt : per_cnt + 12'h001);
            frame_seen <= frame_seen | frame_tick;
            if (frame_tick) clock_fault <= frame_seen & ~period_ok;
            else if (per_cnt > per_max) clock_fault <= 1'b1;
        end
    end

    // Fade walks one half-dB step per frame; a stopped frame clock freezes the walk
    function automatic logic [7:0] next_gain(input logic [7:0] cur, input logic [7:0] tgt,
                                             input logic fade, input logic tick);
        if (!fade) return tgt;
        if (!tick || cur == tgt) return cur;
        return (cur < tgt) ? cur + 8'h01 : cur - 8'h01;
    endfunction : next_gain
    wire fade_on = vcfg[aac_pkg::BIT_FADE];
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            gain_l <= aac_pkg::RST_VOLUME;
            gain_r <= aac_pkg::RST_VOLUME;
        end else begin
            gain_l <= next_gain(gain_l, vol_l, fade_on, frame_tick);
            gain_r <= next_gain(gain_r, vol_r, fade_on, frame_tick);
        end
    end

    // Output controls
    aac_pkg::aac_ctrl_s next_ctrl;
    wire [4:0] mult = aac_pkg::RATE_MULT[ostage[6:4]];
    wire any_fault = fault_oc | fault_dc | fault_ot | clock_fault;
    always_comb begin
        next_ctrl.amplifier_active = pwr[aac_pkg::BIT_SHUTDOWN_N] & ~any_fault;
        next_ctrl.power_stage_sleep = pwr[aac_pkg::BIT_SLEEP];
        next_ctrl.speed_range_select = speed;
        next_ctrl.input_format = dig[2:0];
        next_ctrl.hpf_bypass = dig[aac_pkg::BIT_HPF];
        next_ctrl.digital_boost = dig[5:4];
        next_ctrl.gain_left = gain_l;
        next_ctrl.gain_right = gain_r;
        next_ctrl.mute_left = vcfg[aac_pkg::BIT_MUTE_L] | (gain_l < aac_pkg::VOL_MUTE_BELOW);
        next_ctrl.mute_right = vcfg[aac_pkg::BIT_MUTE_R] | (gain_r < aac_pkg::VOL_MUTE_BELOW);
        next_ctrl.parallel_bridge_on = ostage[aac_pkg::BIT_PARALLEL];
        next_ctrl.parallel_source_channel = ostage[aac_pkg::BIT_SRC_CH];
        next_ctrl.switch_multiple = speed ? {1'b0, mult[4:1]} : mult;
        next_ctrl.analog_gain = ostage[3:2];
        next_ctrl.overcurrent_quarters = aac_pkg::OC_QUARTERS[oc_scale];
        next_ctrl.clip_threshold = {pwr[7:2], clip_mid, clip_low[7:2]};
    end
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) ctrl_out <= '0;
        else ctrl_out <= next_ctrl;
    end

    // Checks
    sequence seq_good_frame;
        frame_tick && period_ok;
    endsequence
    sequence seq_reg_byte;
        scl_fall && !bus_start && !bus_stop && state == aac_pkg::I2C_REG && byte_in;
    endsequence
    a_clock_recover: assert property (@(posedge clk_in) disable iff (rst_in)
        seq_good_frame |=> !clock_fault ##1 (!ctrl_out.amplifier_active || !$past(any_fault)))
        else $error("Clock fault not cleared after good frame");
    a_reg_ack: assert property (@(posedge clk_in) disable iff (rst_in)
        seq_reg_byte |=> sda_oe_out && ptr == $past(sh))
        else $error("Register address byte not acknowledged");
    a_overcurrent_hold: assert property (@(posedge clk_in) disable iff (rst_in)
        fault_oc && pwr[0] |=> fault_oc ##1 !ctrl_out.amplifier_active)
        else $error("Overcurrent flag dropped without shutdown");
    a_dc_halt: assert property (@(posedge clk_in) disable iff (rst_in)
        dc_s |-> ##2 !ctrl_out.amplifier_active)
        else $error("DC offset fault did not halt output");
    a_overheat_clear: assert property (@(posedge clk_in) disable iff (rst_in)
        !pwr[0] && !ot_s |=> !fault_ot)
        else $error("Overheat flag not cleared in shutdown");
    a_fade_step: assert property (@(posedge clk_in) disable iff (rst_in)
        fade_on && frame_tick && gain_l < vol_l |=> gain_l == $past(gain_l) + 8'h01)
        else $error("Fade step wrong");
    a_fade_off: assert property (@(posedge clk_in) disable iff (rst_in)
        !fade_on |=> ##1 ctrl_out.gain_left == $past(vol_l, 2))
        else $error("Gain did not jump with fade off");
    a_low_code_mute: assert property (@(posedge clk_in) disable iff (rst_in)
        gain_r < 8'h07 |=> ctrl_out.mute_right)
        else $error("Low volume code not muted");
    a_rate_half: assert property (@(posedge clk_in) disable iff (rst_in)
        speed && ostage[6:4] == 3'h7 |=> ctrl_out.switch_multiple == 5'h0C)
        else $error("Double speed multiple not halved");
    a_format_legal: assert property (@(posedge clk_in) disable iff (rst_in)
        dig[2:0] <= 3'h5)
        else $error("Reserved input format stored");
endmodule : aac_regs

// ===== shared/aac_pkg.sv
// Register map, reset values, timing constants and carrier types of the amplifier control bank
// Functional notes
// - Speed select 0 accepts 32/44.1/48 kHz frames, 1 accepts 88.2/96 kHz.
// - Format 000-011 right-justified 24/20/18/16, 100 I2S default, 101 left; none above.
// - Volume config bit 7 enables fading; resets to 1.
// - Channel mute bit (1 right, 0 left) forces that output to 50/50 duty.
// - Volume code steps 0.5 dB: 0xFF +24 dB, 0xCF 0 dB default, 0x07 -100 dB.
// - Volume code below 0x07 mutes the channel.
// - Output stage bit 7: 0 stereo bridge, 1 mono parallel bridge.
// - Parallel bridge takes right channel when source bit is 0, left when 1.
// - Rate codes 0-7 give 6,8,10,12,14,16,20,24 times frame clock; default 16x.
// - Double speed halves the switching multiple of every rate code.
// - Analog gain 00 19.2, 01 22.6, 10 25 dBV; 11 never written.
// - Overcurrent scale 00 nominal, 01 75%, 10 50%, 11 25%.
// - Clock fault bit 3 follows the error and clears itself when clocks recover.
// - Overcurrent latches bit 2 and halts until the shutdown bit toggles.
// - DC offset latches bit 1 and halts until the shutdown bit toggles.
// - Overheat latches bit 0 and halts until the shutdown bit toggles.
// - Clip threshold is 20 bits: power reg 7:2, reg 0x10, reg 0x11 bits 7:2.
// - Power bit 0 low shuts down, high releases; toggling clears latched faults.
// - Write is device address, register address, data, each byte acknowledged.
package aac_pkg;
    localparam logic [7:0] REG_ID = 8'h00;
    localparam logic [7:0] REG_POWER = 8'h01;
    localparam logic [7:0] REG_DIGITAL = 8'h02;
    localparam logic [7:0] REG_VOLCFG = 8'h03;
    localparam logic [7:0] REG_LEFT = 8'h04;
    localparam logic [7:0] REG_RIGHT = 8'h05;
    localparam logic [7:0] REG_OUTSTAGE = 8'h06;
    localparam logic [7:0] REG_FAULT = 8'h08;
    localparam logic [7:0] REG_CLIP_MID = 8'h10;
    localparam logic [7:0] REG_CLIP_LOW = 8'h11;

    localparam logic [7:0] RST_POWER = 8'hFD;
    localparam logic [7:0] RST_DIGITAL = 8'h14;
    localparam logic [7:0] RST_VOLCFG = 8'h80;
    localparam logic [7:0] RST_VOLUME = 8'hCF;
    localparam logic [7:0] RST_OUTSTAGE = 8'h51;
    localparam logic [1:0] RST_OC_SCALE = 2'h0;
    localparam logic [7:0] RST_CLIP_MID = 8'hFF;
    localparam logic [7:0] RST_CLIP_LOW = 8'hFC;

    localparam logic [7:0] WMASK_DIGITAL = 8'hBF;
    localparam logic [7:0] WMASK_VOLCFG = 8'h83;
    localparam logic [2:0] FMT_LAST = 3'h5;
    localparam logic [1:0] GAIN_RESERVED = 2'h3;
    localparam logic [7:0] VOL_MUTE_BELOW = 8'h07;

    localparam int BIT_SHUTDOWN_N = 0;
    localparam int BIT_SLEEP = 1;
    localparam int BIT_SPEED = 3;
    localparam int BIT_HPF = 7;
    localparam int BIT_FADE = 7;
    localparam int BIT_MUTE_R = 1;
    localparam int BIT_MUTE_L = 0;
    localparam int BIT_PARALLEL = 7;
    localparam int BIT_SRC_CH = 1;

    localparam logic [4:0] RATE_MULT [8] = '{5'h06, 5'h08, 5'h0A, 5'h0C,
                                             5'h0E, 5'h10, 5'h14, 5'h18};
    localparam logic [2:0] OC_QUARTERS [4] = '{3'h4, 3'h3, 3'h2, 3'h1};

    // Frame period windows with margin around the legal sample rates
    localparam int CLK_PERIOD_NS = 50;
    localparam int SS_FRAME_MIN_NS = 19000;
    localparam int SS_FRAME_MAX_NS = 34000;
    localparam int DS_FRAME_MIN_NS = 9500;
    localparam int DS_FRAME_MAX_NS = 12500;
    localparam int SS_MIN_CYC = (SS_FRAME_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int SS_MAX_CYC = SS_FRAME_MAX_NS / CLK_PERIOD_NS;
    localparam int DS_MIN_CYC = (DS_FRAME_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int DS_MAX_CYC = DS_FRAME_MAX_NS / CLK_PERIOD_NS;

    typedef enum {I2C_IDLE, I2C_DEV, I2C_REG, I2C_WR, I2C_RD} aac_i2c_e;

    typedef struct packed {
        logic amplifier_active;
        logic power_stage_sleep;
        logic speed_range_select;
        logic [2:0] input_format;
        logic hpf_bypass;
        logic [1:0] digital_boost;
        logic [7:0] gain_left;
        logic [7:0] gain_right;
        logic mute_left;
        logic mute_right;
        logic parallel_bridge_on;
        logic parallel_source_channel;
        logic [4:0] switch_multiple;
        logic [1:0] analog_gain;
        logic [2:0] overcurrent_quarters;
        logic [19:0] clip_threshold;
    } aac_ctrl_s;
endpackage : aac_pkg

// ===== verification/aac_host.sv
// I2C host model that configures and reads the control bank
`timescale 1ns/1ns
module aac_host #(
    parameter logic [6:0] ADDR = 7'h2A // Value is arbitrary
) (
    input wire logic clk_in,
    input wire logic sda_oe_in,
    output logic scl_out,
    output logic sda_out
);
    logic drv = 1'b1;
    int nacks = 0;
    // Pull-up: the line is high unless someone pulls it low
    assign sda_out = drv & ~sda_oe_in;
    initial scl_out = 1'b1;
    task automatic hp();
        repeat (10) @(posedge clk_in);
        #2;
    endtask : hp
    task automatic bitx(input logic b, output logic s);
        drv = b;
        hp();
        scl_out = 1'b1;
        hp();
        s = sda_out;
        scl_out = 1'b0;
    endtask : bitx
    task automatic start();
        drv = 1'b1;
        hp();
        scl_out = 1'b1;
        hp();
        drv = 1'b0;
        hp();
        scl_out = 1'b0;
    endtask : start
    task automatic tx(input logic [7:0] d);
        logic s;
        for (int i = 7; i >= 0; i--) bitx(d[i], s);
        bitx(1'b1, s);
        nacks += int'(s);
    endtask : tx
    task automatic wr(input logic [7:0] a, input logic [7:0] q[$]);
        start();
        tx({ADDR, 1'b0});
        tx(a);
        foreach (q[i]) tx(q[i]);
        drv = 1'b0;
        hp();
        scl_out = 1'b1;
        hp();
        drv = 1'b1;
        hp();
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        logic s;
        start();
        tx({ADDR, 1'b0});
        tx(a);
        start();
        tx({ADDR, 1'b1});
        for (int i = 0; i < 8; i++) begin
            bitx(1'b1, s);
            d = {d[6:0], s};
        end
        // Not-acknowledge ends the read, then stop
        bitx(1'b1, s);
        wr_stop();
    endtask : rd
    task automatic wr_stop();
        drv = 1'b0;
        hp();
        scl_out = 1'b1;
        hp();
        drv = 1'b1;
        hp();
    endtask : wr_stop
endmodule : aac_host

// ===== verification/aac_regs_tb.sv
// Self-checking bench for the amplifier control bank
`timescale 1ns/1ns
module aac_regs_tb;
    localparam logic [6:0] DA = 7'h2A; // Value is arbitrary
    logic clk_in = 0, rst_in = 1, sclk = 0, lrck = 0, scl, sda, oe, sd;
    logic [2:0] flt = 0;
    logic [7:0] d;
    logic [7:0] m [18];
    logic [31:0] r, seed = 32'hd384_660c;
    int miscompares = 0, tests_run = 0;
    aac_pkg::aac_ctrl_s ctrl;
    always #25 clk_in = ~clk_in;
    always #16 sclk = ~sclk;
    // Frame near 48 kHz
    always begin
        repeat (326) @(posedge sclk);
        #2 lrck = ~lrck;
    end
    aac_regs #(.DEVICE_ADDR(DA)) dut (.clk_in(clk_in), .rst_in(rst_in), .sclk_in(sclk),
        .lrck_in(lrck), .scl_in(scl), .sda_in(sda), .sda_data_out(sd), .sda_oe_out(oe),
        .overcurrent_in(flt[2]), .dc_offset_in(flt[1]), .overheat_in(flt[0]), .ctrl_out(ctrl));
    aac_host #(.ADDR(DA)) host (.clk_in(clk_in), .sda_oe_in(oe), .scl_out(scl), .sda_out(sda));
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : rnd
    function automatic aac_pkg::aac_ctrl_s ex(input logic act);
        int mt [8] = '{6, 8, 10, 12, 14, 16, 20, 24};
        return '{act & m[1][0], m[1][1], m[2][3], m[2][2:0], m[2][7], m[2][5:4], m[4], m[5],
            m[3][0] | (m[4] < 8'h07), m[3][1] | (m[5] < 8'h07), m[6][7], m[6][1],
            5'(mt[m[6][6:4]] >> m[2][3]), m[6][3:2], 3'(4 - m[8][5:4]),
            {m[1][7:2], m[16], m[17][7:2]}};
    endfunction : ex
    task automatic chk(input string n, input logic [63:0] s, input logic [63:0] e);
        tests_run++;
        if (s !== e) begin
            miscompares++;
            $display("BAD %s expected %h seen %h", n, e, s);
        end
    endtask : chk
    task automatic w(input logic [7:0] a, input logic [7:0] q[$]);
        foreach (q[i]) m[a + i] = q[i];
        host.wr(a, q);
        repeat (5) @(posedge clk_in);
    endtask : w
    task automatic print_verdict();
        chk("acks", host.nacks, 0);
        $display("compares %0d mismatches %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : print_verdict
    initial begin
        repeat (90000) @(posedge clk_in);
        miscompares++;
        print_verdict();
    end
    initial begin
        m = '{8'hFD, 8'hFD, 8'h14, 8'h80, 8'hCF, 8'hCF, 8'h51, 0, 0, 0, 0, 0, 0, 0, 0, 0,
            8'hFF, 8'hFC};
        m[0] = 8'h00;
        repeat (6) @(posedge clk_in);
        #2 rst_in = 0;
        repeat (2000) @(posedge clk_in);
        chk("reset", ctrl, ex(1));
        host.rd(8'h03, d);
        chk("fade_rst", d, 8'h80);
        // Reserved registers never touched
        for (int k = 0; k < 8; k++) begin
            r = rnd();
            w(8'h01, '{{r[7:1], 1'b1}});
            r = rnd();
            w(8'h02, '{{r[7], 1'b0, r[5:4], 1'b0, 3'(r[10:8] % 6)}, {6'h00, r[17:16]},
                k == 0 ? 8'h07 : r[31:24], k == 0 ? 8'h06 : r[23:16],
                {r[15], 3'(k), 2'(k % 3), r[20], 1'b1}});
            w(8'h08, '{{2'b00, 2'(k), 4'hF}});
            r = rnd();
            w(8'h10, '{r[7:0], {r[13:8], 2'b00}});
            chk("ctrl", ctrl, ex(1));
            host.rd(8'h08, d);
            chk("status", d, {2'b00, m[8][5:4], 4'h0});
            host.rd(8'(k % 6 + 1), d);
            chk("readback", d, m[k % 6 + 1]);
        end
        for (int i = 0; i < 3; i++) begin
            @(posedge clk_in);
            #2 flt = 3'b100 >> i;
            repeat (20) @(posedge clk_in);
            #2 flt = 0;
            repeat (5) @(posedge clk_in);
            chk("halt", ctrl.amplifier_active, 0);
            host.rd(8'h08, d);
            chk("flag", d[2 - i], 1);
            w(8'h01, '{m[1] & 8'hFE});
            chk("shutdown", ctrl, ex(1));
            w(8'h01, '{m[1] | 8'h01});
            chk("resume", ctrl, ex(1));
            host.rd(8'h08, d);
            chk("cleared", d, {2'b00, m[8][5:4], 4'h0});
        end
        w(8'h02, '{m[2] | 8'h08});
        repeat (1500) @(posedge clk_in);
        chk("speed", ctrl, ex(0));
        host.rd(8'h08, d);
        chk("clk_flag", d[3], 1);
        w(8'h02, '{m[2] & 8'hF7});
        repeat (2000) @(posedge clk_in);
        chk("recover", ctrl, ex(1));
        w(8'h03, '{8'h00, 8'hCF});
        w(8'h03, '{8'h80, 8'hD3});
        chk("fade_step", ctrl.gain_left == 8'hD3, 0);
        repeat (3000) @(posedge clk_in);
        chk("fade_end", ctrl, ex(1));
        chk("sda_data", sd, 0);
        print_verdict();
    end
endmodule : aac_regs_tb
